// ===== design/nsc_station.sv
// Station parameters and transmit policy of one network station.
// Assumes a frame layer outside that reports bus activity and takes
// frames on a one-cycle request, and a program engine that pulses
// cycle start and end.
`timescale 1ns/10ps
// Operation
// - Station number resets to zero.
// - Only numbers one to eight count as valid addresses.
// - Bit rate resets to 125 kilobaud.
// - Bit rate selector accepts only the seven listed rates.
// - All stations share one bit rate, spread from station one.
// - Network pause between send cycles is determined by the network.
// - Pause multiplier resets to zero, leaving the pause unchanged.
// - Multiplier one to fifteen gives pause times one plus n.
// - Multiplier one doubles the pause.
// - All stations share one multiplier, spread from station one.
// - Change push resets enabled.
// - With push on, each I/O change goes out in its own telegram.
// - A station without program pushes every change regardless.
// - Follow master mode resets enabled.
// - Stations two to eight follow station one run and stop.
// - Program and display stations follow only in status or text view.
// - Remote I/O on a program-less station two to eight serves station one.
// - Loading a program clears remote I/O mode.
// - Display stations refuse remote I/O mode.
// - Only messages for our own number enter the receive store.
// - Send store changes go out only while the bus is idle.
// - Receive data feed program image; image refreshes send store.
module nsc_station
	import nsc_pkg::*;
#(
	parameter int AW = 3, // Receive store address width.
	parameter int DW = 16, // Data word width.
	parameter logic HAS_DISPLAY = 1'b0 // Station has a display.
) (
	input wire logic ref_clk_i, // Clock, 125 MHz.
	input wire logic reset_n_i, // Asynchronous reset, active low.
	input wire logic [3:0] reg_addr_i, // Register address.
	input wire logic [15:0] reg_wdata_i, // Register write data.
	input wire logic reg_wr_i, // Register write strobe.
	input wire logic reg_rd_i, // Register read strobe.
	output logic [15:0] reg_rdata_o, // Read data, one cycle later.
	input wire logic has_program_i, // A user program is loaded.
	input wire logic prog_load_i, // Pulse: a program was loaded.
	input wire logic status_view_i, // Screen shows status or text.
	input wire logic master_run_i, // Station one is in run mode.
	input wire logic master_mode_chg_i, // Pulse: station one changed mode.
	input wire logic local_run_i, // Local run request.
	input wire logic io_change_i, // Pulse: local input or output changed.
	input wire logic bus_busy_i, // A message is on the bus.
	input wire logic rx_valid_i, // Pulse: message received.
	input wire logic [3:0] rx_dest_i, // Message destination number.
	input wire logic [AW-1:0] rx_addr_i, // Message word index.
	input wire logic [DW-1:0] rx_data_i, // Message word.
	input wire logic cycle_start_i, // Pulse: program cycle begins.
	input wire logic cycle_end_i, // Pulse: program cycle ends.
	input wire logic [DW-1:0] image_out_i, // Updated image data.
	input wire logic [AW-1:0] image_addr_i, // Image word to load.
	input wire logic tx_done_i, // Pulse: frame layer sent the frame.
	output logic [DW-1:0] image_in_o, // Word copied into program image.
	output logic image_we_o, // Image word valid.
	output logic tx_req_o, // Pulse: send a user-data frame.
	output logic tx_change_o, // Frame is a change-push telegram.
	output logic [DW-1:0] tx_data_o, // Frame data.
	output logic [2:0] baud_o, // Selected bit rate code.
	output logic run_o, // Station in run mode.
	output logic remote_io_o // Station acts as remote I/O unit.
);
	logic [3:0] station_number_r;
	nsc_baud_t baud_r;
	logic [3:0] pause_multiplier_r;
	logic send_io_r;
	logic follow_r;
	logic remote_io_en_r;
	logic [NSC_PAUSE_W-1:0] net_pause_time_r;
	logic run_r;
	logic [DW-1:0] send_store_r;
	logic send_dirty_r;
	logic change_pend_r;
	nsc_tx_state_t state_r;
	logic [NSC_PAUSE_W+3:0] pause_cnt_r;
	logic [AW-1:0] img_cnt_r;
	logic img_busy_r;
	logic img_rd_r;
	logic station_valid;
	logic follower;
	logic remote_active;
	logic push_change;
	logic launch;

	nsc_store_if #(.AW(AW), .DW(DW)) rx_if ();

	// ==========================================================
	// Helpers
	function automatic logic nsc_in_range(input logic [3:0] n,
		input logic [3:0] lo);
		nsc_in_range = (n >= lo) && (n <= NSC_STN_MAX);
	endfunction : nsc_in_range

	// The top code is reserved, so a write of it leaves the rate alone.
	function automatic logic nsc_baud_ok(input logic [2:0] c);
		nsc_baud_ok = (c <= 3'(NSC_BR_1000K));
	endfunction : nsc_baud_ok

	assign station_valid = nsc_in_range(station_number_r, NSC_STN_MIN);
	assign follower = follow_r &&
		nsc_in_range(station_number_r, NSC_STN_MIN + 4'h1);
	// Display stations never become remote units.
	assign remote_active = remote_io_en_r && !has_program_i && !HAS_DISPLAY &&
		nsc_in_range(station_number_r, NSC_STN_MIN + 4'h1);
	// A program-less unit has no other way to report its I/O.
	assign push_change = io_change_i &&
		(send_io_r || !has_program_i);
	// The frame request goes out the cycle after the sequencer sees a free bus.
	assign launch = (state_r == NSC_WAIT_BUS) && station_valid &&
		!bus_busy_i;

	// ==========================================================
	// Configuration registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			station_number_r <= NSC_STN_UNASSIGNED;
			baud_r <= NSC_BR_RESET;
			pause_multiplier_r <= NSC_PMUL_RESET;
			send_io_r <= NSC_SEND_IO_RESET;
			follow_r <= NSC_FOLLOW_RESET;
			remote_io_en_r <= NSC_REMOTE_IO_RESET;
			net_pause_time_r <= NSC_NETPAUSE_RESET;
		end else begin
			if (reg_wr_i) begin
				case (reg_addr_i)
					NSC_A_STATION: begin
						// Out-of-range numbers fall back to unassigned.
						if (nsc_in_range(reg_wdata_i[3:0], NSC_STN_MIN)) begin
							station_number_r <= reg_wdata_i[3:0];
						end else begin
							station_number_r <= NSC_STN_UNASSIGNED;
						end
					end
					NSC_A_BAUD: begin
						if (nsc_baud_ok(reg_wdata_i[2:0])) begin
							baud_r <= nsc_baud_t'(reg_wdata_i[2:0]);
						end
					end
					NSC_A_PAUSE: begin
						pause_multiplier_r <= reg_wdata_i[3:0];
					end
					NSC_A_OPTIONS: begin
						send_io_r <= reg_wdata_i[NSC_OPT_SEND_IO];
						follow_r <= reg_wdata_i[NSC_OPT_FOLLOW];
						remote_io_en_r <= reg_wdata_i[NSC_OPT_REMOTE_IO] &&
							!HAS_DISPLAY;
					end
					NSC_A_NETPAUSE: begin
						// Pause agreed among stations, given by the frame layer.
						net_pause_time_r <= reg_wdata_i;
					end
					default: begin
					end
				endcase
			end
			// A program load wins over a same-cycle option write.
			if (prog_load_i) begin
				remote_io_en_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Register read port
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				NSC_A_STATION: reg_rdata_o <= {12'h000, station_number_r};
				NSC_A_BAUD: reg_rdata_o <= {13'h0, baud_r};
				NSC_A_PAUSE: reg_rdata_o <= {12'h000, pause_multiplier_r};
				NSC_A_OPTIONS: begin
					reg_rdata_o <= {13'h0, remote_io_en_r, follow_r, send_io_r};
				end
				// Transmit busy covers the pause as well as the frame.
				NSC_A_STATUS: begin
					reg_rdata_o <= {12'h000, (state_r != NSC_IDLE),
						remote_active, run_r, station_valid};
				end
				NSC_A_NETPAUSE: reg_rdata_o <= net_pause_time_r;
				default: reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// ==========================================================
	// Run and stop
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			run_r <= 1'b0;
		end else if (remote_active) begin
			run_r <= master_run_i;
		end else if (follower && master_mode_chg_i) begin
			// A display station with a program only follows in status view.
			if (!(HAS_DISPLAY && has_program_i) || status_view_i) begin
				run_r <= master_run_i;
			end
		end else if (!follower || station_number_r == NSC_STN_MASTER) begin
			// Station one never follows; it keeps its own run request.
			run_r <= local_run_i;
		end
	end

	// ==========================================================
	// Receive store and program image transfer
	assign rx_if.we = rx_valid_i && station_valid &&
		(rx_dest_i == station_number_r);
	assign rx_if.waddr = rx_addr_i;
	assign rx_if.wdata = rx_data_i;
	assign rx_if.raddr = img_cnt_r;

	nsc_store #(.AW(AW), .DW(DW)) u_rx_store (
		.ref_clk_i(ref_clk_i),
		.bus(rx_if.mem)
	);

	// The whole store walks into the image at each cycle start.
	// A start pulse during a walk is ignored, so no half copy is taken.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			img_cnt_r <= '0;
			img_busy_r <= 1'b0;
			img_rd_r <= 1'b0;
			image_we_o <= 1'b0;
			image_in_o <= '0;
		end else begin
			img_rd_r <= img_busy_r;
			image_we_o <= img_rd_r;
			image_in_o <= rx_if.rdata;
			if (cycle_start_i && !img_busy_r) begin
				img_busy_r <= 1'b1;
				img_cnt_r <= '0;
			end else if (img_busy_r) begin
				img_cnt_r <= img_cnt_r + 1'b1;
				if (&img_cnt_r) begin
					img_busy_r <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Send store and change push
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			send_store_r <= '0;
			send_dirty_r <= 1'b0;
			change_pend_r <= 1'b0;
		end else begin
			if (cycle_end_i && image_out_i != send_store_r) begin
				send_store_r <= image_out_i;
				send_dirty_r <= 1'b1;
			end else if (launch && !change_pend_r) begin
				// Cleared at a launch with no push pending, so an update while the frame is out
				// raises the flag again instead of being lost.
				send_dirty_r <= 1'b0;
			end
			// A new change in the launch cycle keeps the push pending.
			if (push_change) begin
				change_pend_r <= 1'b1;
			end else if (launch) begin
				change_pend_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Transmit sequencer with stretched pause
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= NSC_IDLE;
			pause_cnt_r <= '0;
			tx_req_o <= 1'b0;
			tx_change_o <= 1'b0;
			tx_data_o <= '0;
		end else begin
			tx_req_o <= 1'b0;
			case (state_r)
				NSC_IDLE: begin
					if ((send_dirty_r || change_pend_r) && station_valid) begin
						state_r <= NSC_WAIT_BUS;
					end
				end
				NSC_WAIT_BUS: begin
					if (!station_valid) begin
						state_r <= NSC_IDLE;
					end else if (!bus_busy_i) begin
						state_r <= NSC_SEND;
						tx_req_o <= 1'b1;
						tx_change_o <= change_pend_r;
						tx_data_o <= send_store_r;
					end
				end
				NSC_SEND: begin
					if (tx_done_i) begin
						state_r <= NSC_PAUSE;
						// Pause is the net pause times one plus n; four spare
						// bits keep the largest product from wrapping.
						pause_cnt_r <= {4'h0, net_pause_time_r} *
							({{NSC_PAUSE_W{1'b0}}, pause_multiplier_r} +
							1'b1);
					end
				end
				NSC_PAUSE: begin
					if (pause_cnt_r <= 1) begin
						state_r <= NSC_IDLE;
						pause_cnt_r <= '0;
					end else begin
						pause_cnt_r <= pause_cnt_r - 1'b1;
					end
				end
				default: state_r <= NSC_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Output registers
	// Registered so the pins never show a decode glitch.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			baud_o <= 3'(NSC_BR_RESET);
			run_o <= 1'b0;
			remote_io_o <= 1'b0;
		end else begin
			baud_o <= baud_r;
			run_o <= run_r;
			remote_io_o <= remote_active;
		end
	end
endmodule : nsc_station

// ===== design/nsc_store.sv
// Small word store used as the receive store of one station.
// Assumes the owner writes and reads on the same clock.
`timescale 1ns/10ps
module nsc_store #(
	parameter int AW = 3, // Address width.
	parameter int DW = 16 // Word width.
) (
	input wire logic ref_clk_i, // Clock.
	nsc_store_if.mem bus // Store port.
);
	logic [DW-1:0] mem_r [0:(1<<AW)-1];
	logic [DW-1:0] rdata_r;

	// ==========================================================
	// Storage with registered read.
	always_ff @(posedge ref_clk_i) begin
		if (bus.we) begin
			mem_r[bus.waddr] <= bus.wdata;
		end
		rdata_r <= mem_r[bus.raddr];
	end
	assign bus.rdata = rdata_r;
endmodule : nsc_store

// ===== shared/nsc_pkg.sv
// Constants and types shared by the station configuration block.
// Assumes a 125 MHz reference clock; no bus offsets are needed.
package nsc_pkg;
	// ==========================================================
	// Station numbers
	localparam logic [3:0] NSC_STN_UNASSIGNED = 4'h0;
	localparam logic [3:0] NSC_STN_MIN = 4'h1;
	localparam logic [3:0] NSC_STN_MAX = 4'h8;
	localparam logic [3:0] NSC_STN_MASTER = 4'h1;
	// ==========================================================
	// Bit rate selector codes
	typedef enum logic [2:0] {
		NSC_BR_10K = 3'h0,
		NSC_BR_20K = 3'h1,
		NSC_BR_50K = 3'h2,
		NSC_BR_125K = 3'h3,
		NSC_BR_250K = 3'h4,
		NSC_BR_500K = 3'h5,
		NSC_BR_1000K = 3'h6
	} nsc_baud_t;
	localparam nsc_baud_t NSC_BR_RESET = NSC_BR_125K;
	// ==========================================================
	// Pause multiplier and other reset values
	localparam logic [3:0] NSC_PMUL_RESET = 4'h0;
	localparam logic [3:0] NSC_PMUL_MAX = 4'hf;
	localparam logic NSC_SEND_IO_RESET = 1'b1;
	localparam logic NSC_FOLLOW_RESET = 1'b1;
	localparam logic NSC_REMOTE_IO_RESET = 1'b1;
	// ==========================================================
	// Register addresses of the plain register port
	localparam logic [3:0] NSC_A_STATION = 4'h0;
	localparam logic [3:0] NSC_A_BAUD = 4'h1;
	localparam logic [3:0] NSC_A_PAUSE = 4'h2;
	localparam logic [3:0] NSC_A_OPTIONS = 4'h3;
	localparam logic [3:0] NSC_A_STATUS = 4'h4;
	localparam logic [3:0] NSC_A_NETPAUSE = 4'h5;
	// Option bit positions.
	localparam int NSC_OPT_SEND_IO = 0;
	localparam int NSC_OPT_FOLLOW = 1;
	localparam int NSC_OPT_REMOTE_IO = 2;
	// Status bit positions.
	localparam int NSC_ST_VALID = 0;
	localparam int NSC_ST_RUN = 1;
	localparam int NSC_ST_REMOTE = 2;
	localparam int NSC_ST_TXBUSY = 3;
	// Pause time width in bits; the time counts clock cycles.
	localparam int NSC_PAUSE_W = 16;
	localparam logic [NSC_PAUSE_W-1:0] NSC_NETPAUSE_RESET = 16'h0010;
	// Clock rate for designers sizing the pause count.
	localparam int NSC_CLK_MHZ = 125;
	typedef enum {
		NSC_IDLE,
		NSC_WAIT_BUS,
		NSC_SEND,
		NSC_PAUSE
	} nsc_tx_state_t;
endpackage : nsc_pkg

// ===== shared/nsc_store_if.sv
// Interface between the station logic and its receive store.
// Assumes one clock shared by both modules.
`timescale 1ns/10ps
interface nsc_store_if #(parameter int AW = 3, parameter int DW = 16);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport owner (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : nsc_store_if

// ===== sim/nsc_peer.sv
// Far side model: frame layer and the other stations on the bus.
// Assumes one shared clock; a frame holds the bus for a fixed time.
`timescale 1ns/10ps
module nsc_peer (
	input wire logic ref_clk_i, // Clock.
	input wire logic reset_n_i, // Reset, active low.
	input wire logic tx_req_i, // Send request from the block.
	input wire logic slow_i, // Long frames.
	input wire logic other_i, // Another station is sending.
	output logic bus_busy_o, // Bus carries a message.
	output logic tx_done_o // Frame finished.
);
	logic [3:0] left_r;
	// ==========================================================
	// Frame timing
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			left_r <= 4'h0;
			tx_done_o <= 1'b0;
		end else begin
			tx_done_o <= (left_r == 4'h1);
			if (tx_req_i)
				left_r <= slow_i ? 4'hc : 4'h3;
			else if (left_r != 4'h0)
				left_r <= left_r - 4'h1;
		end
	end
	// Traffic of other stations keeps the block off the bus.
	assign bus_busy_o = (left_r != 4'h0) || other_i;
endmodule : nsc_peer

// ===== sim/nsc_station_props.sv
// Port checker for the station block.
// Assumes it is bound onto nsc_station with the same widths.
`timescale 1ns/10ps
module nsc_station_props
	import nsc_pkg::*;
#(
	parameter int AW = 3, // Store address width.
	parameter int DW = 16 // Data word width.
) (
	input wire logic ref_clk_i, // Clock.
	input wire logic reset_n_i, // Reset, active low.
	input wire logic reg_rd_i, // Read strobe.
	input wire logic [15:0] reg_rdata_o, // Read data.
	input wire logic has_program_i, // Program loaded.
	input wire logic prog_load_i, // Program load pulse.
	input wire logic bus_busy_i, // Bus busy.
	input wire logic cycle_start_i, // Cycle start.
	input wire logic image_we_o, // Image word valid.
	input wire logic tx_req_o, // Send request.
	input wire logic [DW-1:0] tx_data_o, // Frame data.
	input wire logic [2:0] baud_o, // Bit rate code.
	input wire logic remote_io_o // Remote unit.
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	baud_reset_a: assert property ($rose(reset_n_i) |->
		baud_o == 3'(NSC_BR_RESET))
		else $error("bit rate not at reset code");
	baud_legal_a: assert property (baud_o != 3'h7)
		else $error("illegal bit rate code");
	idle_bus_a: assert property (tx_req_o |-> !$past(bus_busy_i))
		else $error("send on a busy bus");
	send_pulse_a: assert property (tx_req_o |=> !tx_req_o)
		else $error("send request too long");
	load_clear_a: assert property (prog_load_i |-> ##2 !remote_io_o)
		else $error("remote mode kept after load");
	prog_remote_a: assert property (has_program_i [*2] |=> !remote_io_o)
		else $error("remote mode with a program");
	image_walk_a: assert property (cycle_start_i |-> ##[1:4] image_we_o)
		else $error("image copy did not start");
	data_hold_a: assert property (!tx_req_o |-> $stable(tx_data_o))
		else $error("frame data moved");
	read_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
		else $error("read data outside its cycle");
endmodule : nsc_station_props

// ===== sim/tb.sv
// Self-checking bench for the station block.
// Assumes the peer model stands for the frame layer.
`timescale 1ns/10ps
module tb;
	import nsc_pkg::*;
	logic ref_clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0, has_program_i = 1'b1, prog_load_i = 1'b0;
	logic master_run_i = 1'b0, master_mode_chg_i = 1'b0, local_run_i = 1'b0;
	logic io_change_i = 1'b0, rx_valid_i = 1'b0, cycle_start_i = 1'b0;
	logic cycle_end_i = 1'b0, other_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0, rx_dest_i = 4'h0;
	logic [2:0] rx_addr_i = 3'h0, baud_o;
	logic [15:0] reg_wdata_i = 16'h0, rx_data_i = 16'h0, image_out_i = 16'h0;
	logic bus_busy_i, tx_done_i, image_we_o, tx_req_o, tx_change_o;
	logic run_o, remote_io_o;
	logic [15:0] reg_rdata_o, image_in_o, tx_data_o;
	logic [15:0] img [8];
	int img_n = 0, tx_n = 0, mismatches = 0, check_count = 0;
	nsc_station u_nsc_station (.ref_clk_i, .reset_n_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .has_program_i,
		.prog_load_i, .status_view_i(1'b1), .master_run_i, .master_mode_chg_i,
		.local_run_i, .io_change_i, .bus_busy_i, .rx_valid_i, .rx_dest_i,
		.rx_addr_i, .rx_data_i, .cycle_start_i, .cycle_end_i, .image_out_i,
		.image_addr_i(3'h0), .tx_done_i, .image_in_o, .image_we_o, .tx_req_o,
		.tx_change_o, .tx_data_o, .baud_o, .run_o, .remote_io_o);
	nsc_peer u_nsc_peer (.ref_clk_i, .reset_n_i, .tx_req_i(tx_req_o),
		.slow_i(1'b0), .other_i, .bus_busy_o(bus_busy_i), .tx_done_o(tx_done_i));
	always #4 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		if (tx_req_o === 1'b1)
			tx_n <= tx_n + 1;
		if (image_we_o === 1'b1) begin
			img[img_n[2:0]] <= image_in_o;
			img_n <= img_n + 1;
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 cmp(e, reg_rdata_o);
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : cyc
	task automatic push;
		@(posedge ref_clk_i);
		io_change_i <= 1'b1;
		@(posedge ref_clk_i);
		io_change_i <= 1'b0;
		#1;
	endtask : push
	task automatic wait_tx(output int c);
		c = 0;
		while (tx_req_o !== 1'b1 && c < 200) begin
			cyc(1);
			c++;
		end
	endtask : wait_tx
	task automatic sent(input logic chg);
		int c;
		wait_tx(c);
		cmp(16'h1, 16'(c < 200));
		cmp({15'h0, chg}, {15'h0, tx_change_o});
	endtask : sent
	task automatic quiet_push;
		int n0;
		n0 = tx_n;
		push();
		cyc(40);
		cmp(16'h0, 16'(tx_n - n0));
	endtask : quiet_push
	task automatic mode(input logic r);
		@(posedge ref_clk_i);
		master_run_i <= r;
		master_mode_chg_i <= 1'b1;
		@(posedge ref_clk_i);
		master_mode_chg_i <= 1'b0;
		cyc(3);
	endtask : mode
	task automatic rx(input logic [3:0] d, input logic [15:0] v);
		@(posedge ref_clk_i);
		rx_valid_i <= 1'b1;
		rx_dest_i <= d;
		rx_addr_i <= 3'h2;
		rx_data_i <= v;
		@(posedge ref_clk_i);
		rx_valid_i <= 1'b0;
	endtask : rx
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		cyc(1);
		cmp(16'h3, {13'h0, baud_o});
		chk(NSC_A_STATUS, 16'h0);
		chk(NSC_A_STATION, 16'h0);
		chk(NSC_A_BAUD, 16'h3);
		chk(NSC_A_PAUSE, 16'h0);
		chk(NSC_A_OPTIONS, 16'h7);
		chk(NSC_A_NETPAUSE, 16'h10);
		chk(4'hf, 16'h0);
	endtask : t_reset
	task automatic t_numbers;
		for (int i = 0; i < 16; i++) begin
			wr(NSC_A_STATION, 16'(i));
			chk(NSC_A_STATION, (i >= 1 && i <= 8) ? 16'(i) : 16'h0);
		end
		for (int i = 0; i < 8; i++) begin
			wr(NSC_A_BAUD, 16'(i));
			chk(NSC_A_BAUD, (i < 7) ? 16'(i) : 16'h6);
			cmp((i < 7) ? 16'(i) : 16'h6, {13'h0, baud_o});
		end
	endtask : t_numbers
	task automatic t_push;
		quiet_push();
		wr(NSC_A_STATION, 16'h3);
		@(posedge ref_clk_i);
		other_i <= 1'b1;
		quiet_push();
		@(posedge ref_clk_i);
		other_i <= 1'b0;
		sent(1'b1);
	endtask : t_push
	task automatic t_pause;
		int c, g;
		int ms[3] = '{0, 1, 15};
		wr(NSC_A_NETPAUSE, 16'h8);
		for (int k = 0; k < 3; k++) begin
			wr(NSC_A_PAUSE, 16'(ms[k]));
			push();
			wait_tx(c);
			push();
			wait_tx(c);
			// The gap holds the frame, the pause and a few handshake cycles.
			g = c + 2 - 8 * (1 + ms[k]);
			cmp(16'h1, 16'(g >= 4 && g <= 12));
		end
	endtask : t_pause
	task automatic t_modes;
		wr(NSC_A_OPTIONS, 16'h6);
		quiet_push();
		@(posedge ref_clk_i);
		has_program_i <= 1'b0;
		push();
		sent(1'b1);
		wr(NSC_A_OPTIONS, 16'h7);
		// Station one runs its own program while this unit serves it.
		master_run_i <= 1'b1;
		cyc(3);
		cmp(16'h1, {15'h0, remote_io_o});
		cmp(16'h1, {15'h0, run_o});
		chk(NSC_A_STATUS, 16'hf);
		@(posedge ref_clk_i);
		has_program_i <= 1'b1;
		prog_load_i <= 1'b1;
		@(posedge ref_clk_i);
		prog_load_i <= 1'b0;
		cyc(2);
		cmp(16'h0, {15'h0, remote_io_o});
		chk(NSC_A_OPTIONS, 16'h3);
		mode(1'b0);
		cmp(16'h0, {15'h0, run_o});
		@(posedge ref_clk_i);
		master_run_i <= 1'b1;
		cyc(3);
		cmp(16'h0, {15'h0, run_o});
		mode(1'b1);
		cmp(16'h1, {15'h0, run_o});
		wr(NSC_A_STATION, 16'h1);
		local_run_i <= 1'b1;
		mode(1'b0);
		cmp(16'h1, {15'h0, run_o});
	endtask : t_modes
	task automatic t_data;
		wr(NSC_A_STATION, 16'h3);
		rx(4'h3, 16'ha5c3);
		rx(4'h5, 16'h3c5a);
		img_n = 0;
		cycle_start_i <= 1'b1;
		@(posedge ref_clk_i);
		cycle_start_i <= 1'b0;
		cyc(30);
		cmp(16'h8, 16'(img_n));
		cmp(16'ha5c3, img[2]);
		@(posedge ref_clk_i);
		image_out_i <= 16'h5a3c;
		cycle_end_i <= 1'b1;
		@(posedge ref_clk_i);
		cycle_end_i <= 1'b0;
		sent(1'b0);
		cmp(16'h5a3c, tx_data_o);
	endtask : t_data
	task automatic complete_run;
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (6) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_numbers();
		@(posedge ref_clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_push();
		t_pause();
		t_modes();
		t_data();
		complete_run();
	end
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule : tb
bind nsc_station nsc_station_props #(.AW(AW), .DW(DW)) u_props (.ref_clk_i,
	.reset_n_i, .reg_rd_i, .reg_rdata_o, .has_program_i, .prog_load_i,
	.bus_busy_i, .cycle_start_i, .image_we_o, .tx_req_o, .tx_data_o, .baud_o,
	.remote_io_o);
